// File: ufci_pkg.sv
// constants for the serial port fifo control and interrupt identification block
`default_nettype none

package ufci_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets (avalon byte address)
    localparam logic [4:0] UFCI_OFF_RXTX   = 5'h00;
    localparam logic [4:0] UFCI_OFF_IER    = 5'h04;
    localparam logic [4:0] UFCI_OFF_IIDFC  = 5'h08;
    localparam logic [4:0] UFCI_OFF_HCR    = 5'h0c;
    localparam logic [4:0] UFCI_OFF_LSR    = 5'h10;
    localparam logic [4:0] UFCI_OFF_HSR    = 5'h14;
    localparam logic [4:0] UFCI_OFF_LVLCFG = 5'h18;

    ////////////////////////////////////////////////////////////////////////////
    // fifo_control field positions
    localparam int UFCI_FC_EN      = 0;
    localparam int UFCI_FC_RXRST   = 1;
    localparam int UFCI_FC_TXRST   = 2;
    localparam int UFCI_FC_DMA     = 3;
    localparam int UFCI_FC_TRIG_LO = 6;
    localparam int UFCI_FC_TRIG_HI = 7;

    // interrupt_enable_reg positions
    localparam int UFCI_IE_RXRDY = 0;
    localparam int UFCI_IE_TXE   = 1;
    localparam int UFCI_IE_RXST  = 2;
    localparam int UFCI_IE_HS    = 3;

    // handshake_control_reg positions
    localparam int UFCI_HC_DTR  = 0;
    localparam int UFCI_HC_RTS  = 1;
    localparam int UFCI_HC_RI   = 2;
    localparam int UFCI_HC_IRQE = 3;
    localparam int UFCI_HC_LOOP = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] UFCI_FC_RESET  = 8'h00;
    localparam logic [3:0] UFCI_IE_RESET  = 4'h0;
    localparam logic [4:0] UFCI_HC_RESET  = 5'h00;
    localparam logic [1:0] UFCI_LVL_RESET = 2'h0;
    localparam logic       UFCI_TXE_RESET = 1'b1;

    // identification codes, bits 3:0
    localparam logic [3:0] UFCI_IID_NONE = 4'h1;
    localparam logic [3:0] UFCI_IID_RXST = 4'h6;
    localparam logic [3:0] UFCI_IID_RXRD = 4'h4;
    localparam logic [3:0] UFCI_IID_TOUT = 4'hc;
    localparam logic [3:0] UFCI_IID_TXE  = 4'h2;
    localparam logic [3:0] UFCI_IID_HS   = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // receive timeout in character times, fifo size
    localparam logic [2:0] UFCI_TOUT_CHARS = 3'h4;
    localparam int         UFCI_FIFO_W     = 8;
    localparam int         UFCI_FIFO_D     = 8;

    // trigger levels indexed by {level mode, trigger select}
    localparam logic [15:0][6:0] UFCI_TRIG_LVL = {
        7'd124, 7'd120, 7'd116, 7'd112,
        7'd104, 7'd96,  7'd88,  7'd80,
        7'd64,  7'd48,  7'd32,  7'd16,
        7'd14,  7'd8,   7'd4,   7'd1
    };

endpackage : ufci_pkg

`default_nettype wire

// File: ufci_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module ufci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH),
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             clr,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    output logic      [CW-1:0]    count
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////////
    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign count     = cnt_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (clr) begin
            // clear only moves the counters, stale words are never visible
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_d = cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            if (push && !clr) begin
                mem_q[wr_q] <= in_data;
            end
        end
    end

endmodule : ufci_fifo

`default_nettype wire

// File: ufci_top.sv
// serial port fifo control and interrupt identification with avalon register slave
`timescale 1ns/100ps
`default_nettype none

module ufci_top
    import ufci_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             rx_ready,
    input  wire logic        overrun_flag,
    input  wire logic        parity_error_flag,
    input  wire logic        framing_error_flag,
    input  wire logic        break_detect_flag,
    input  wire logic        char_tick,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        dcd_n,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             irq_o,
    output logic             irq_oe,
    output logic             dma_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic        done_q,      done_d;
    logic [7:0]  rdata_q,     rdata_d;
    logic        fifo_en_q,   fifo_en_d;
    logic        dma_sel_q,   dma_sel_d;
    logic [1:0]  trig_sel_q,  trig_sel_d;
    logic [1:0]  lvl_mode_q,  lvl_mode_d;
    logic [3:0]  ier_q,       ier_d;
    logic [4:0]  hcr_q,       hcr_d;
    logic [3:0]  lsr_q,       lsr_d;
    logic [3:0]  chg_q,       chg_d;
    logic [3:0]  mdm_prev_q,  mdm_prev_d;
    logic        txe_q,       txe_d;
    logic        tx_valid_q,  tx_valid_d;
    logic [7:0]  tx_data_q,   tx_data_d;
    logic [2:0]  to_cnt_q,    to_cnt_d;

    // combinational
    logic        req;
    logic        rd_acc;
    logic        wr_acc;
    logic        sel_rxtx, sel_ier, sel_iid, sel_hcr, sel_lsr, sel_hsr, sel_lvl;
    logic        rx_clr;
    logic        tx_clr;
    logic        rx_in_ready;
    logic        rx_out_valid;
    logic [7:0]  rx_out_data;
    logic        rx_pop;
    logic        rx_push;
    logic [3:0]  rx_count;
    logic [6:0]  trig_lvl;
    logic [3:0]  mdm_now;
    logic        pend_rxst, pend_rxrd, pend_tout, pend_txe, pend_hs;
    logic [3:0]  iid;
    logic [7:0]  iid_byte;
    logic [7:0]  rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: every access answers on its second cycle
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~done_q;
    assign rd_acc          = avs_read & done_q;
    assign wr_acc          = avs_write & done_q & avs_byteenable[0];
    assign avs_readdata    = {24'h000000, rdata_q};

    assign sel_rxtx = (avs_address == UFCI_OFF_RXTX);
    assign sel_ier  = (avs_address == UFCI_OFF_IER);
    assign sel_iid  = (avs_address == UFCI_OFF_IIDFC);
    assign sel_hcr  = (avs_address == UFCI_OFF_HCR);
    assign sel_lsr  = (avs_address == UFCI_OFF_LSR);
    assign sel_hsr  = (avs_address == UFCI_OFF_HSR);
    assign sel_lvl  = (avs_address == UFCI_OFF_LVLCFG);

    // fifo resets are strobes, never stored
    assign rx_clr = wr_acc & sel_iid & avs_writedata[UFCI_FC_RXRST];
    assign tx_clr = wr_acc & sel_iid & avs_writedata[UFCI_FC_TXRST];

    ////////////////////////////////////////////////////////////////////////////
    // receive fifo; without fifo mode it behaves as a single holding byte
    assign rx_ready = rx_in_ready & (fifo_en_q | (rx_count == 4'h0)) & ~rx_clr;
    assign rx_push  = rx_valid & rx_ready;
    assign rx_pop   = rd_acc & sel_rxtx & rx_out_valid;

    ufci_fifo #(
        .WIDTH (UFCI_FIFO_W),
        .DEPTH (UFCI_FIFO_D)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .clr       (rx_clr),
        .in_valid  (rx_valid & ~rx_clr & (fifo_en_q | (rx_count == 4'h0))),
        .in_data   (rx_data),
        .in_ready  (rx_in_ready),
        .out_valid (rx_out_valid),
        .out_data  (rx_out_data),
        .out_ready (rx_pop),
        .count     (rx_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // modem inputs, loopback takes them from the control bits
    always_comb begin
        if (hcr_q[UFCI_HC_LOOP]) begin
            mdm_now = {hcr_q[UFCI_HC_IRQE], hcr_q[UFCI_HC_RI], hcr_q[UFCI_HC_DTR], hcr_q[UFCI_HC_RTS]};
        end else begin
            mdm_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
        end
    end

    assign rts_n    = ~(hcr_q[UFCI_HC_RTS] & ~hcr_q[UFCI_HC_LOOP]);
    assign dtr_n    = ~(hcr_q[UFCI_HC_DTR] & ~hcr_q[UFCI_HC_LOOP]);
    assign dma_mode = fifo_en_q & dma_sel_q;
    assign tx_valid = tx_valid_q;
    assign tx_data  = tx_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt sources and priority
    // levels above the fifo depth can never be met with the 8 entry buffer
    assign trig_lvl  = UFCI_TRIG_LVL[{lvl_mode_q, trig_sel_q}];
    assign pend_rxst = ier_q[UFCI_IE_RXST] & (|lsr_q);
    assign pend_rxrd = ier_q[UFCI_IE_RXRDY] &
                       (fifo_en_q ? ({3'h0, rx_count} >= trig_lvl) : rx_out_valid);
    assign pend_tout = ier_q[UFCI_IE_RXRDY] & fifo_en_q & (to_cnt_q == UFCI_TOUT_CHARS);
    assign pend_txe  = ier_q[UFCI_IE_TXE] & txe_q;
    assign pend_hs   = ier_q[UFCI_IE_HS] & (|chg_q);

    always_comb begin
        if (pend_rxst) begin
            iid = UFCI_IID_RXST;
        end else if (pend_rxrd) begin
            iid = UFCI_IID_RXRD;
        end else if (pend_tout) begin
            iid = UFCI_IID_TOUT;
        end else if (pend_txe) begin
            iid = UFCI_IID_TXE;
        end else if (pend_hs) begin
            iid = UFCI_IID_HS;
        end else begin
            iid = UFCI_IID_NONE;
        end
    end

    assign iid_byte = {{2{fifo_en_q}}, 2'b00, iid};
    assign irq_o    = ~iid[0];
    assign irq_oe   = hcr_q[UFCI_HC_IRQE];

    ////////////////////////////////////////////////////////////////////////////
    // read mux; fifo control has no read path, its offset returns ident
    always_comb begin
        rd_mux = 8'h00;
        if (sel_rxtx) begin
            rd_mux = rx_out_valid ? rx_out_data : 8'h00;
        end else if (sel_ier) begin
            rd_mux = {4'h0, ier_q};
        end else if (sel_iid) begin
            rd_mux = iid_byte;
        end else if (sel_hcr) begin
            rd_mux = {3'h0, hcr_q};
        end else if (sel_lsr) begin
            rd_mux = {1'b0, ~tx_valid_q, ~tx_valid_q, lsr_q, rx_out_valid};
        end else if (sel_hsr) begin
            rd_mux = {mdm_now, chg_q};
        end else if (sel_lvl) begin
            rd_mux = {6'h00, lvl_mode_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state; clears use the captured read value so a set always wins
    always_comb begin
        done_d     = req & ~done_q;
        rdata_d    = rdata_q;
        fifo_en_d  = fifo_en_q;
        dma_sel_d  = dma_sel_q;
        trig_sel_d = trig_sel_q;
        lvl_mode_d = lvl_mode_q;
        ier_d      = ier_q;
        hcr_d      = hcr_q;
        lsr_d      = lsr_q;
        chg_d      = chg_q;
        mdm_prev_d = mdm_now;
        txe_d      = txe_q;
        tx_valid_d = tx_valid_q;
        tx_data_d  = tx_data_q;
        to_cnt_d   = to_cnt_q;

        if (avs_read && !done_q) begin
            rdata_d = rd_mux;
        end

        if (wr_acc && sel_iid) begin
            fifo_en_d  = avs_writedata[UFCI_FC_EN];
            dma_sel_d  = avs_writedata[UFCI_FC_DMA];
            trig_sel_d = avs_writedata[UFCI_FC_TRIG_HI:UFCI_FC_TRIG_LO];
        end
        if (wr_acc && sel_ier) begin
            ier_d = avs_writedata[3:0];
        end
        if (wr_acc && sel_hcr) begin
            hcr_d = avs_writedata[4:0];
        end
        if (wr_acc && sel_lvl) begin
            lvl_mode_d = avs_writedata[1:0];
        end

        // receive status flags
        if (rd_acc && sel_lsr) begin
            lsr_d = lsr_q & ~rdata_q[4:1];
        end
        lsr_d = lsr_d | {break_detect_flag, framing_error_flag, parity_error_flag, overrun_flag};

        // handshake change flags
        if (rd_acc && sel_hsr) begin
            chg_d = chg_q & ~rdata_q[3:0];
        end
        chg_d[0] = chg_d[0] | (mdm_now[0] ^ mdm_prev_q[0]);
        chg_d[1] = chg_d[1] | (mdm_now[1] ^ mdm_prev_q[1]);
        chg_d[2] = chg_d[2] | (mdm_prev_q[2] & ~mdm_now[2]);
        chg_d[3] = chg_d[3] | (mdm_now[3] ^ mdm_prev_q[3]);

        // transmit holding byte and empty flag
        if (rd_acc && sel_iid && rdata_q[3:0] == UFCI_IID_TXE) begin
            txe_d = 1'b0;
        end
        if (tx_valid_q && tx_ready) begin
            tx_valid_d = 1'b0;
            txe_d      = 1'b1;
        end
        if (wr_acc && sel_rxtx) begin
            // a write while full is dropped, the byte in flight is kept
            if (!tx_valid_q || tx_ready) begin
                tx_valid_d = 1'b1;
                tx_data_d  = avs_writedata[7:0];
            end
            txe_d = 1'b0;
        end
        if (tx_clr) begin
            tx_valid_d = 1'b0;
            txe_d      = 1'b1;
        end

        // receive timeout in character times since last fifo access
        if (!fifo_en_q || !rx_out_valid || rx_push || rx_pop || rx_clr) begin
            to_cnt_d = 3'h0;
        end else if (char_tick && to_cnt_q != UFCI_TOUT_CHARS) begin
            to_cnt_d = to_cnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            done_q     <= 1'b0;
            rdata_q    <= 8'h00;
            fifo_en_q  <= UFCI_FC_RESET[UFCI_FC_EN];
            dma_sel_q  <= UFCI_FC_RESET[UFCI_FC_DMA];
            trig_sel_q <= UFCI_FC_RESET[UFCI_FC_TRIG_HI:UFCI_FC_TRIG_LO];
            lvl_mode_q <= UFCI_LVL_RESET;
            ier_q      <= UFCI_IE_RESET;
            hcr_q      <= UFCI_HC_RESET;
            lsr_q      <= 4'h0;
            chg_q      <= 4'h0;
            mdm_prev_q <= 4'h0;
            txe_q      <= UFCI_TXE_RESET;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            to_cnt_q   <= 3'h0;
        end else if (ce) begin
            done_q     <= done_d;
            rdata_q    <= rdata_d;
            fifo_en_q  <= fifo_en_d;
            dma_sel_q  <= dma_sel_d;
            trig_sel_q <= trig_sel_d;
            lvl_mode_q <= lvl_mode_d;
            ier_q      <= ier_d;
            hcr_q      <= hcr_d;
            lsr_q      <= lsr_d;
            chg_q      <= chg_d;
            mdm_prev_q <= mdm_prev_d;
            txe_q      <= txe_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q  <= tx_data_d;
            to_cnt_q   <= to_cnt_d;
        end
    end

endmodule : ufci_top

`default_nettype wire

// File: ufci_props.sv
// concurrent checks on the ports of the fifo control and identification block
`timescale 1ns/100ps
`default_nettype none

module ufci_props
    import ufci_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        rx_ready,
    input wire logic        tx_valid,
    input wire logic        irq_o,
    input wire logic        irq_oe,
    input wire logic        dma_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // accepted bus cycles, the step that every register effect hangs on
    sequence s_wr(logic [4:0] a);
        ce && avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == a;
    endsequence
    sequence s_rd(logic [4:0] a);
        ce && avs_read && !avs_waitrequest && avs_address == a;
    endsequence

    a_one_wait: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    a_dma_select: assert property (s_wr(UFCI_OFF_IIDFC) |=> dma_mode == $past(avs_writedata[0] && avs_writedata[3]))
        else $error("dma mode does not follow enable and select");
    a_tx_reset: assert property (s_wr(UFCI_OFF_IIDFC) ##0 avs_writedata[0] && avs_writedata[2] |=> !tx_valid)
        else $error("transmit byte survives transmit reset");
    a_rx_reset: assert property (s_wr(UFCI_OFF_IIDFC) ##0 avs_writedata[0] && avs_writedata[1] |-> ##[1:2] rx_ready)
        else $error("receive side not empty after receive reset");
    a_ident_layout: assert property (s_rd(UFCI_OFF_IIDFC) |-> avs_readdata[7] == avs_readdata[6]
        && avs_readdata[5:4] == 2'h0 && avs_readdata[31:8] == 24'h0)
        else $error("identification layout broken");
    a_idle_bit: assert property (s_rd(UFCI_OFF_IIDFC) |-> avs_readdata[0] == !$past(irq_o))
        else $error("pending bit disagrees with interrupt output");
    a_timeout_code: assert property (s_rd(UFCI_OFF_IIDFC) ##0 avs_readdata[3] |-> avs_readdata[7:0] == 8'hcc)
        else $error("bit 3 set without fifo timeout code");
    a_enables_off: assert property (s_wr(UFCI_OFF_IER) ##0 avs_writedata[3:0] == 4'h0 |=> !irq_o [*2])
        else $error("interrupt with every source disabled");
    a_pin_enable: assert property (s_wr(UFCI_OFF_HCR) |=> irq_oe == $past(avs_writedata[3]))
        else $error("interrupt pin enable does not follow control bit");
endmodule : ufci_props

bind ufci_top ufci_props u_ufci_props (.clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_ready, .tx_valid, .irq_o, .irq_oe, .dma_mode);

`default_nettype wire

// File: ufci_line_model.sv
// serial side stand-in: receive byte source, transmit sink, character tick
`timescale 1ns/100ps
`default_nettype none

module ufci_line_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ld,
    input  wire logic [3:0] cnt,
    input  wire logic [7:0] base,
    input  wire logic       stall,
    input  wire logic       tick_en,
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            tx_ready,
    output logic            char_tick
);
    logic [3:0] left_q;
    logic [7:0] nxt_q;
    logic [1:0] div_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            left_q <= 4'h0;
            nxt_q  <= 8'h00;
            div_q  <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
            if (ld) begin
                left_q <= cnt;
                nxt_q  <= base;
            end else if (rx_valid && rx_ready) begin
                left_q <= left_q - 4'h1;
                nxt_q  <= nxt_q + 8'h01;
            end
        end
    end

    assign rx_valid  = left_q != 4'h0;
    // idle data inverted so a stale byte can never pass as fresh
    assign rx_data   = rx_valid ? nxt_q : ~nxt_q;
    assign tx_ready  = !stall;
    // short character time keeps the timeout run brief
    assign char_tick = tick_en && div_q == 2'h0;
endmodule : ufci_line_model

`default_nettype wire

// File: ufci_top_tb.sv
// self-checking bench for the fifo control and identification block
`timescale 1ns/100ps
`default_nettype none

module ufci_top_tb
    import ufci_pkg::*;
;
    logic        clk, rst, ce, avs_read, avs_write, stall, tick_en, ld, cts_n, ri_n;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable, cnt, err;
    logic [7:0]  base;
    wire logic [31:0] avs_readdata;
    wire logic        avs_waitrequest, rx_ready, rx_valid, tx_valid, tx_ready, char_tick, irq_o, irq_oe, dma_mode;
    wire logic        rts_n, dtr_n;
    wire logic [7:0]  rx_data, tx_data;
    int          fails, tests_run;

    ufci_top u_ufci_top (.clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .rx_valid, .rx_data, .rx_ready, .overrun_flag(err[0]),
        .parity_error_flag(err[1]), .framing_error_flag(err[2]), .break_detect_flag(err[3]), .char_tick,
        .tx_valid, .tx_data, .tx_ready, .cts_n, .dsr_n(1'b1), .ri_n, .dcd_n(1'b1), .rts_n, .dtr_n,
        .irq_o, .irq_oe, .dma_mode);
    ufci_line_model u_ufci_line_model (.clk, .rst, .ld, .cnt, .base, .stall, .tick_en, .rx_ready, .rx_valid,
        .rx_data, .tx_ready, .char_tick);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("counts: %0d compared, %0d mismatched", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h wanted %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= rd;
        avs_write     <= !rd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fails++;
            close_out();
        end
    endtask : bus

    task wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : wr

    task rc(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b1, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask : rc

    // bounded wait for the interrupt pin or for the source to go idle
    task settle(input logic irq);
        int k;
        k = 0;
        while (k < 60 && (irq ? irq_o !== 1'b1 : rx_valid !== 1'b0)) begin
            @(posedge clk);
            k++;
        end
        if (k == 60) begin
            fails++;
            close_out();
        end
    endtask : settle

    task push(input logic [3:0] n, input logic [7:0] b);
        @(posedge clk);
        ld   <= 1'b1;
        cnt  <= n;
        base <= b;
        @(posedge clk);
        ld <= 1'b0;
        @(posedge clk);
        settle(1'b0);
    endtask : push

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rc(UFCI_OFF_IIDFC, 8'h01);
        chk({30'h0, irq_oe, dma_mode}, 32'h0);
        rc(5'h1c, 8'h00);
    endtask : t_reset

    task t_dma;
        wr(UFCI_OFF_IIDFC, 8'h09);
        @(negedge clk);
        chk({31'h0, dma_mode}, 32'h1);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        wr(UFCI_OFF_IIDFC, 8'h08);
        @(negedge clk);
        chk({31'h0, dma_mode}, 32'h0);
        rc(UFCI_OFF_IIDFC, 8'h01);
        wr(UFCI_OFF_IIDFC, 8'h01);
    endtask : t_dma

    task t_txe;
        wr(UFCI_OFF_HCR, 8'h08);
        @(negedge clk);
        chk({31'h0, irq_oe}, 32'h1);
        wr(UFCI_OFF_IER, 8'h02);
        rc(UFCI_OFF_IIDFC, 8'hc2);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        stall <= 1'b1;
        wr(UFCI_OFF_RXTX, 8'h5a);
        @(negedge clk);
        chk({23'h0, tx_valid, tx_data}, 32'h15a);
        wr(UFCI_OFF_IIDFC, 8'h05);
        @(negedge clk);
        chk({31'h0, tx_valid}, 32'h0);
        stall <= 1'b0;
        wr(UFCI_OFF_RXTX, 8'h33);
        rc(UFCI_OFF_IIDFC, 8'hc2);
        stall <= 1'b1;
        wr(UFCI_OFF_RXTX, 8'h44);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        wr(UFCI_OFF_IIDFC, 8'h05);
        stall <= 1'b0;
        wr(UFCI_OFF_IER, 8'h00);
    endtask : t_txe

    task t_rx;
        wr(UFCI_OFF_IIDFC, 8'h41);
        wr(UFCI_OFF_IER, 8'h01);
        push(4'h3, 8'h10);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        push(4'h1, 8'h13);
        rc(UFCI_OFF_IIDFC, 8'hc4);
        rc(UFCI_OFF_RXTX, 8'h10);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        tick_en <= 1'b1;
        settle(1'b1);
        tick_en <= 1'b0;
        rc(UFCI_OFF_IIDFC, 8'hcc);
        rc(UFCI_OFF_RXTX, 8'h11);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        // reset lands with bytes still queued from the previous pass
        for (int s = 0; s < 4; s++) begin
            wr(UFCI_OFF_IIDFC, {s[1:0], 6'h03});
            rc(UFCI_OFF_RXTX, 8'h00);
            push((s == 0) ? 4'h1 : (s == 1) ? 4'h4 : 4'h8, 8'h20);
            rc(UFCI_OFF_IIDFC, (s == 3) ? 8'hc1 : 8'hc4);
        end
        @(negedge clk);
        chk({31'h0, rx_ready}, 32'h0);
        wr(UFCI_OFF_IIDFC, 8'h01);
        for (int m = 1; m < 4; m++) begin
            wr(UFCI_OFF_LVLCFG, 8'(m));
            rc(UFCI_OFF_IIDFC, 8'hc1);
        end
        wr(UFCI_OFF_LVLCFG, 8'h00);
        rc(UFCI_OFF_IIDFC, 8'hc4);
        for (int i = 0; i < 8; i++) rc(UFCI_OFF_RXTX, 8'(32'h20 + i));
        rc(UFCI_OFF_IIDFC, 8'hc1);
    endtask : t_rx

    task t_err;
        logic [31:0] q;
        wr(UFCI_OFF_IER, 8'h05);
        push(4'h1, 8'h55);
        for (int i = 0; i < 4; i++) begin
            err <= 4'(1 << i);
            @(posedge clk);
            err <= 4'h0;
            rc(UFCI_OFF_IIDFC, 8'hc6);
            bus(1'b1, UFCI_OFF_LSR, 8'h00, q);
            chk(q & 32'h1f, {27'h0, 4'(1 << i), 1'b1});
            rc(UFCI_OFF_IIDFC, 8'hc4);
        end
        rc(UFCI_OFF_RXTX, 8'h55);
    endtask : t_err

    task t_hs;
        wr(UFCI_OFF_IER, 8'h08);
        cts_n <= 1'b0;
        rc(UFCI_OFF_IIDFC, 8'hc0);
        rc(UFCI_OFF_HSR, 8'h11);
        rc(UFCI_OFF_IIDFC, 8'hc1);
        ri_n <= 1'b0;
        rc(UFCI_OFF_HSR, 8'h50);
        ri_n <= 1'b1;
        rc(UFCI_OFF_HSR, 8'h14);
        rc(UFCI_OFF_HSR, 8'h10);
        // loopback feeds the status bits from the control bits, pins held inactive
        wr(UFCI_OFF_HCR, 8'h13);
        rc(UFCI_OFF_HSR, 8'h32);
        chk({30'h0, rts_n, dtr_n}, 32'h3);
        wr(UFCI_OFF_HCR, 8'h0b);
        @(negedge clk);
        chk({30'h0, rts_n, dtr_n}, 32'h0);
        cts_n <= 1'b1;
        wr(UFCI_OFF_IER, 8'h00);
        rc(UFCI_OFF_IIDFC, 8'hc1);
    endtask : t_hs

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, ce, avs_byteenable} = 6'h3f;
        {avs_read, avs_write, stall, tick_en, ld, err} = 9'h000;
        {cts_n, ri_n} = 2'h3;
        {avs_address, avs_writedata, cnt, base} = 49'h0;
        {fails, tests_run} = 64'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_dma();
        t_txe();
        t_rx();
        t_err();
        t_hs();
        close_out();
    end
endmodule : ufci_top_tb

`default_nettype wire
